// file: hdl/acr_regs.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "acr_defs.svh"

module acr_regs
  import acr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic      [1:0]        avs_response_o,
  output logic                   avs_waitrequest_o,
  output logic      [23:0]       ch5_gain_o,
  output logic                   ch5_gain_unity_o,
  output logic      [23:0]       ch6_gain_o,
  output logic                   ch6_gain_unity_o,
  output logic      [23:0]       ch6_offset_o,
  output logic                   ch6_offset_zero_o,
  output logic      [9:0]        ch6_phase_shift_o,
  output logic                   ch6_dc_removal_bypass_o,
  output logic      [1:0]        ch6_input_select_o,
  output logic      [3:0]        ch6_route_o
);

  localparam int JOINS = 3;
  localparam logic [JOINS-1:0][23:0] NEUTRALS = {
    `ACR_RST_OFF_FULL,
    `ACR_RST_GAIN_FULL,
    `ACR_RST_GAIN_FULL
  };

  acr_regs_state_t st;
  acr_regs_state_t next_st;

  logic [JOINS-1:0][15:0] join_upper;
  logic [JOINS-1:0][7:0]  join_lower;
  logic [JOINS-1:0][23:0] join_value;
  logic [JOINS-1:0]       join_neutral;

  logic [5:0]  reg_index;
  logic        addr_aligned;
  logic        addr_high_zero;
  logic        mapped;
  logic [15:0] wr_half;
  logic [1:0]  wr_lanes;
  logic [15:0] rd_value;

  // Index of a word when the byte address is word aligned
  function automatic logic acr_hit(input logic [5:0] index, input logic [5:0] target);
    acr_hit = (index == target);
  endfunction

  // Unlisted indices answer with a decode error and read zero
  function automatic logic acr_is_mapped(input logic [5:0] index);
    acr_is_mapped = acr_hit(index, `ACR_IDX_CH5_GAIN_UP) ||
                    acr_hit(index, `ACR_IDX_CH5_GAIN_LO) ||
                    acr_hit(index, `ACR_IDX_CH6_SETUP)   ||
                    acr_hit(index, `ACR_IDX_CH6_OFF_UP)  ||
                    acr_hit(index, `ACR_IDX_CH6_OFF_LO)  ||
                    acr_hit(index, `ACR_IDX_CH6_GAIN_UP) ||
                    acr_hit(index, `ACR_IDX_CH6_GAIN_LO) ||
                    acr_hit(index, `ACR_IDX_TRIM_STATUS);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] acr_merge(input logic [15:0] old_val,
                                            input logic [15:0] new_val,
                                            input logic [1:0]  lanes);
    acr_merge[7:0]  = lanes[0] ? new_val[7:0]  : old_val[7:0];
    acr_merge[15:8] = lanes[1] ? new_val[15:8] : old_val[15:8];
  endfunction

  // Lower trim registers keep their value in the upper byte; the low byte reads zero
  function automatic logic [15:0] acr_low_view(input logic [7:0] low);
    acr_low_view = {low, 8'h00};
  endfunction

  function automatic logic [3:0] acr_route(input logic [1:0] sel);
    case (sel)
      `ACR_SEL_PINS:     acr_route = 4'h1;
      `ACR_SEL_SHORT:    acr_route = 4'h2;
      `ACR_SEL_POS_TEST: acr_route = 4'h4;
      `ACR_SEL_NEG_TEST: acr_route = 4'h8;
      default:           acr_route = 4'h1;
    endcase
  endfunction

  // A wider bus must keep its extra address bits at zero, or aliases would appear
  generate
    if (ADDR_W > 8) begin : g_high_addr
      assign addr_high_zero = (avs_address_i[ADDR_W-1:8] == '0);
    end else begin : g_no_high_addr
      assign addr_high_zero = 1'b1;
    end
  endgenerate

  assign reg_index    = avs_address_i[7:2];
  assign addr_aligned = (avs_address_i[1:0] == 2'h0) && addr_high_zero;
  assign mapped       = addr_aligned && acr_is_mapped(reg_index);
  assign wr_half      = avs_writedata_i[15:0];
  assign wr_lanes     = avs_byteenable_i[1:0];

  // Read view; reserved fields and the upper half word are forced to zero
  always_comb begin
    rd_value = 16'h0000;
    case (reg_index)
      `ACR_IDX_CH5_GAIN_UP: begin
        rd_value = st.gain5_hi;
      end
      `ACR_IDX_CH5_GAIN_LO: begin
        rd_value = acr_low_view(st.gain5_lo);
      end
      `ACR_IDX_CH6_SETUP: begin
        rd_value = {st.phase, 3'h0, st.bypass, st.sel};
      end
      `ACR_IDX_CH6_OFF_UP: begin
        rd_value = st.off6_hi;
      end
      `ACR_IDX_CH6_OFF_LO: begin
        rd_value = acr_low_view(st.off6_lo);
      end
      `ACR_IDX_CH6_GAIN_UP: begin
        rd_value = st.gain6_hi;
      end
      `ACR_IDX_CH6_GAIN_LO: begin
        rd_value = acr_low_view(st.gain6_lo);
      end
      // Flags come from the join stage, so they trail a trim write by one cycle
      `ACR_IDX_TRIM_STATUS: begin
        rd_value = {{(16-JOINS){1'b0}}, join_neutral};
      end
      default: begin
        rd_value = 16'h0000;
      end
    endcase
  end

  always_comb begin
    next_st             = st;
    next_st.waitrequest = 1'b1;
    // Route follows select one cycle late, like the other derived outputs
    next_st.route       = acr_route(st.sel);
    case (st.bus_state)
      ACR_BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          next_st.bus_state   = ACR_BUS_ANSWER;
          next_st.waitrequest = 1'b0;
          if (mapped) begin
            next_st.response = `ACR_RESP_OKAY;
          end else begin
            next_st.response = `ACR_RESP_DECODE_ERR;
          end
          // A write answer leaves the data of the last read standing
          if (avs_read_i && mapped) begin
            next_st.readdata = {16'h0000, rd_value};
          end else if (avs_read_i) begin
            next_st.readdata = 32'h0000_0000;
          end
        end
      end
      ACR_BUS_ANSWER: begin
        // The write lands on the edge where the master sees waitrequest low
        next_st.bus_state = ACR_BUS_IDLE;
        if (avs_write_i && mapped) begin
          case (reg_index)
            `ACR_IDX_CH5_GAIN_UP: begin
              next_st.gain5_hi = acr_merge(st.gain5_hi, wr_half, wr_lanes);
            end
            `ACR_IDX_CH5_GAIN_LO: begin
              if (wr_lanes[1]) begin
                next_st.gain5_lo = wr_half[`ACR_LOW_TRIM_MSB:`ACR_LOW_TRIM_LSB];
              end
            end
            // Phase straddles both byte lanes; each lane writes only its own slice
            `ACR_IDX_CH6_SETUP: begin
              if (wr_lanes[1]) begin
                next_st.phase[9:2] = wr_half[`ACR_PHASE_MSB:8];
              end
              if (wr_lanes[0]) begin
                next_st.phase[1:0] = wr_half[7:`ACR_PHASE_LSB];
                next_st.bypass     = wr_half[`ACR_BYPASS_BIT];
                next_st.sel        = wr_half[`ACR_SEL_MSB:`ACR_SEL_LSB];
              end
            end
            `ACR_IDX_CH6_OFF_UP: begin
              next_st.off6_hi = acr_merge(st.off6_hi, wr_half, wr_lanes);
            end
            `ACR_IDX_CH6_OFF_LO: begin
              if (wr_lanes[1]) begin
                next_st.off6_lo = wr_half[`ACR_LOW_TRIM_MSB:`ACR_LOW_TRIM_LSB];
              end
            end
            `ACR_IDX_CH6_GAIN_UP: begin
              next_st.gain6_hi = acr_merge(st.gain6_hi, wr_half, wr_lanes);
            end
            `ACR_IDX_CH6_GAIN_LO: begin
              if (wr_lanes[1]) begin
                next_st.gain6_lo = wr_half[`ACR_LOW_TRIM_MSB:`ACR_LOW_TRIM_LSB];
              end
            end
            `ACR_IDX_TRIM_STATUS: begin
              // Read-only: the write is answered OKAY and dropped
              next_st.bus_state = ACR_BUS_IDLE;
            end
            default: begin
              next_st.bus_state = ACR_BUS_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_st.bus_state = ACR_BUS_IDLE;
      end
    endcase
  end

  // Reset puts both gains at unity and the offset at zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.bus_state   <= ACR_BUS_IDLE;
      st.waitrequest <= 1'b1;
      st.readdata    <= 32'h0000_0000;
      st.response    <= `ACR_RESP_OKAY;
      st.gain5_hi    <= `ACR_RST_GAIN_UP;
      st.gain5_lo    <= `ACR_RST_ZERO8;
      st.phase       <= 10'h000;
      st.bypass      <= 1'b0;
      st.sel         <= `ACR_SEL_PINS;
      // Must agree with the one-hot code of the reset select
      st.route       <= 4'h1;
      st.off6_hi     <= `ACR_RST_ZERO16;
      st.off6_lo     <= `ACR_RST_ZERO8;
      st.gain6_hi    <= `ACR_RST_GAIN_UP;
      st.gain6_lo    <= `ACR_RST_ZERO8;
    end else begin
      st <= next_st;
    end
  end

  // The datapath sees a joined word one cycle after the register write,
  // but each half is written on its own, so between the two writes the word joins a new half with an old one
  assign join_upper[0] = st.gain5_hi;
  assign join_lower[0] = st.gain5_lo;
  assign join_upper[1] = st.gain6_hi;
  assign join_lower[1] = st.gain6_lo;
  assign join_upper[2] = st.off6_hi;
  assign join_lower[2] = st.off6_lo;

  genvar gi;
  generate
    for (gi = 0; gi < JOINS; gi++) begin : g_join
      acr_trim_join #(
        .NEUTRAL (NEUTRALS[gi])
      ) u_join (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .upper_i   (join_upper[gi]),
        .lower_i   (join_lower[gi]),
        .value_o   (join_value[gi]),
        .neutral_o (join_neutral[gi])
      );
    end
  endgenerate

  // Every output below is a register bit or a join-stage register
  assign avs_readdata_o          = st.readdata;
  assign avs_response_o          = st.response;
  assign avs_waitrequest_o       = st.waitrequest;
  // Unsigned 1.23 multiplier: bit 23 weighs one, top of range is just below two
  assign ch5_gain_o              = join_value[0];
  assign ch5_gain_unity_o        = join_neutral[0];
  assign ch6_gain_o              = join_value[1];
  assign ch6_gain_unity_o        = join_neutral[1];
  // Two's complement offset, passed on without reinterpretation
  assign ch6_offset_o            = join_value[2];
  assign ch6_offset_zero_o       = join_neutral[2];
  assign ch6_phase_shift_o       = st.phase;
  assign ch6_dc_removal_bypass_o = st.bypass;
  assign ch6_input_select_o      = st.sel;
  assign ch6_route_o             = st.route;

endmodule // acr_regs

// file: hdl/acr_defs.svh
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// Register indices; the Avalon byte address is four times the index
`define ACR_IDX_CH5_GAIN_UP   6'h25
`define ACR_IDX_CH5_GAIN_LO   6'h26
`define ACR_IDX_CH6_SETUP     6'h27
`define ACR_IDX_CH6_OFF_UP    6'h28
`define ACR_IDX_CH6_OFF_LO    6'h29
`define ACR_IDX_CH6_GAIN_UP   6'h2A
`define ACR_IDX_CH6_GAIN_LO   6'h2B
`define ACR_IDX_TRIM_STATUS   6'h30

// Reset values
`define ACR_RST_GAIN_UP       16'h8000
`define ACR_RST_ZERO16        16'h0000
`define ACR_RST_ZERO8         8'h00
`define ACR_RST_GAIN_FULL     24'h80_0000
`define ACR_RST_OFF_FULL      24'h00_0000

// Field positions inside the 16-bit registers
`define ACR_PHASE_MSB         15
`define ACR_PHASE_LSB         6
`define ACR_BYPASS_BIT        2
`define ACR_SEL_MSB           1
`define ACR_SEL_LSB           0
`define ACR_LOW_TRIM_MSB      15
`define ACR_LOW_TRIM_LSB      8

// Input select codes
`define ACR_SEL_PINS          2'h0
`define ACR_SEL_SHORT         2'h1
`define ACR_SEL_POS_TEST      2'h2
`define ACR_SEL_NEG_TEST      2'h3

// Avalon response codes
`define ACR_RESP_OKAY         2'h0
`define ACR_RESP_DECODE_ERR   2'h3

`endif

// file: hdl/acr_pkg.sv
`include "acr_defs.svh"

package acr_pkg;

  typedef enum logic [1:0] {
    ACR_BUS_IDLE   = 2'h0,
    ACR_BUS_ANSWER = 2'h1
  } acr_bus_state_t;

  typedef struct packed {
    acr_bus_state_t bus_state;
    logic           waitrequest;
    logic [31:0]    readdata;
    logic [1:0]     response;
    logic [15:0]    gain5_hi;
    logic [7:0]     gain5_lo;
    logic [9:0]     phase;
    logic           bypass;
    logic [1:0]     sel;
    logic [3:0]     route;
    logic [15:0]    off6_hi;
    logic [7:0]     off6_lo;
    logic [15:0]    gain6_hi;
    logic [7:0]     gain6_lo;
  } acr_regs_state_t;

  typedef struct packed {
    logic [23:0] value;
    logic        neutral;
  } acr_join_state_t;

endpackage

// file: hdl/acr_trim_join.sv
`timescale 1ns/1ns
`include "acr_defs.svh"

// Joins an upper and a lower trim register into one 24-bit correction word
module acr_trim_join
  import acr_pkg::*;
#(
  parameter logic [23:0] NEUTRAL = `ACR_RST_GAIN_FULL
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] upper_i,
  input  wire logic [7:0]  lower_i,
  output logic      [23:0] value_o,
  output logic             neutral_o
);

  acr_join_state_t st;
  acr_join_state_t next_st;

  always_comb begin
    next_st         = st;
    next_st.value   = {upper_i, lower_i};
    next_st.neutral = ({upper_i, lower_i} == NEUTRAL);
  end

  // Reset value matches the reset of the source registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{value: NEUTRAL, neutral: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign value_o   = st.value;
  assign neutral_o = st.neutral;

endmodule // acr_trim_join

// file: verification/acr_regs_chk.sv
`timescale 1ns/1ns
module acr_regs_chk (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0]  avs_response_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [23:0] ch5_gain_o,
  input wire logic        ch5_gain_unity_o,
  input wire logic [23:0] ch6_gain_o,
  input wire logic        ch6_gain_unity_o,
  input wire logic [23:0] ch6_offset_o,
  input wire logic        ch6_offset_zero_o,
  input wire logic [1:0]  ch6_input_select_o,
  input wire logic [3:0]  ch6_route_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_taken; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_answer; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  a_answer_next: assert property (s_taken |=> s_answer)
    else $error("answer not one cycle after request");
  a_no_idle_ans: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer without request");
  a_read_high_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_decode_zero: assert property (!avs_waitrequest_o && avs_read_i && avs_response_o == 2'h3
    |-> avs_readdata_o == 32'h0000_0000) else $error("decode error with data");
  a_route_hot: assert property (1'b1 |=> ch6_route_o == (4'h1 << $past(ch6_input_select_o)))
    else $error("route not one-hot of select");
  a_unity_five: assert property (ch5_gain_unity_o == (ch5_gain_o == 24'h80_0000))
    else $error("ch5 unity flag wrong");
  a_unity_six: assert property (ch6_gain_unity_o == (ch6_gain_o == 24'h80_0000))
    else $error("ch6 unity flag wrong");
  a_offset_zero: assert property (ch6_offset_zero_o == (ch6_offset_o == 24'h00_0000))
    else $error("offset zero flag wrong");
  a_join_hold: assert property ((!avs_write_i) [*3] |=> $stable(ch6_offset_o)
    && $stable(ch5_gain_o) && $stable(ch6_gain_o)) else $error("trim changed idle");
endmodule // acr_regs_chk

// file: verification/test_adc_channel_calibration_registers.sv
`timescale 1ns/1ns
module test_adc_channel_calibration_registers;
  import acr_pkg::*;
  logic        clk_sys_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read    = 1'b0;
  logic        avs_write   = 1'b0;
  logic [31:0] avs_wdata   = 32'h0000_0000;
  logic [3:0]  avs_be      = 4'h0;
  logic [31:0] rdata, last_rd;
  logic [1:0]  resp, last_resp, sel;
  logic        wait_r, g5u, g6u, offz, byp;
  logic [23:0] g5, g6, off;
  logic [9:0]  ph;
  logic [3:0]  route;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  acr_regs u_acr_regs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(avs_be), .avs_readdata_o(rdata), .avs_response_o(resp),
    .avs_waitrequest_o(wait_r), .ch5_gain_o(g5), .ch5_gain_unity_o(g5u), .ch6_gain_o(g6),
    .ch6_gain_unity_o(g6u), .ch6_offset_o(off), .ch6_offset_zero_o(offz),
    .ch6_phase_shift_o(ph), .ch6_dc_removal_bypass_o(byp), .ch6_input_select_o(sel),
    .ch6_route_o(route));
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Guards against a hung handshake; the full run needs well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request held until waitrequest is seen low; one idle edge keeps drivers single-assigned
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d,
                     input logic [3:0] be);
    avs_address <= {idx, 2'b00};
    avs_wdata   <= {16'h0000, d};
    avs_be      <= be;
    avs_read    <= ~wr;
    avs_write   <= wr;
    @(posedge clk_sys_i);
    while (wait_r !== 1'b0) @(posedge clk_sys_i);
    last_rd   = rdata;
    last_resp = resp;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] er);
    bus(1'b0, idx, 16'h0000, 4'h3);
    chk("readdata", {16'h0000, exp}, last_rd);
    chk("response", {30'h0, er}, {30'h0, last_resp});
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
    bus(1'b1, idx, d, 4'h3);
    chk("write response", {30'h0, er}, {30'h0, last_resp});
  endtask
  function automatic logic [15:0] mask_of(int i);
    return (i == 1 || i == 4 || i == 6) ? 16'hFF00 : (i == 2) ? 16'hFFC7 : 16'hFFFF;
  endfunction
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 7; i++) begin
      rd(6'(6'h25 + i), (i == 0 || i == 5) ? 16'h8000 : 16'h0000, 2'h0);
    end
    chk("ch5_gain", 24'h80_0000, g5);
    chk("ch6_offset", 24'h00_0000, off);
    chk("ch6_gain", 24'h80_0000, g6);
    chk("unity_flags", 32'h3, {30'h0, g5u, g6u});
    chk("offset_zero", 32'h1, 32'(offz));
    rd(6'h30, 16'h0007, 2'h0);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) bus(1'b1, 6'(6'h25 + i), 16'hFFFF, 4'h3);
    for (int i = 0; i < 7; i++) rd(6'(6'h25 + i), mask_of(i), 2'h0);
    bus(1'b1, 6'h27, 16'h0038, 4'h3);
    rd(6'h27, 16'h0000, 2'h0);
    $display("test access masks done");
    bus(1'b1, 6'h25, 16'h1234, 4'h3);
    bus(1'b1, 6'h26, 16'hABCD, 4'h3);
    bus(1'b1, 6'h2A, 16'hFEDC, 4'h3);
    bus(1'b1, 6'h2B, 16'h0155, 4'h3);
    bus(1'b1, 6'h28, 16'h8001, 4'h3);
    bus(1'b1, 6'h29, 16'h7FFF, 4'h3);
    repeat (2) @(posedge clk_sys_i);
    chk("ch5_gain", 24'h12_34AB, g5);
    chk("ch6_gain", 24'hFE_DC01, g6);
    chk("ch6_offset", 24'h80_017F, off);
    chk("trim_flags", 32'h0, {29'h0, g5u, g6u, offz});
    rd(6'h30, 16'h0000, 2'h0);
    bus(1'b1, 6'h25, 16'hFFFF, 4'h1);
    rd(6'h25, 16'h12FF, 2'h0);
    bus(1'b1, 6'h26, 16'hFFFF, 4'h1);
    rd(6'h26, 16'hAB00, 2'h0);
    $display("test trim values done");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 6'h27, {10'h200 | 10'(s), 3'b111, s[0], s[1:0]}, 4'h3);
      repeat (2) @(posedge clk_sys_i);
      chk("phase", 32'(10'h200 | 10'(s)), 32'(ph));
      chk("bypass", 32'(s[0]), 32'(byp));
      chk("select", 32'(s[1:0]), 32'(sel));
      chk("route", 32'(4'h1 << s), 32'(route));
    end
    bus(1'b1, 6'h27, 16'h0000, 4'h2);
    rd(6'h27, 16'h00C7, 2'h0);
    $display("test channel setup done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("ch5_gain", 24'h80_0000, g5);
    chk("ch6_offset", 24'h00_0000, off);
    chk("phase", 32'h0, 32'(ph));
    chk("setup_bits", 32'h0, {29'h0, byp, sel});
    chk("route", 32'h1, 32'(route));
    rd(6'h27, 16'h0000, 2'h0);
    rd(6'h2B, 16'h0000, 2'h0);
    rd(6'h30, 16'h0007, 2'h0);
    $display("test mid-run reset done");
    wr(6'h30, 16'h0000, 2'h0);
    rd(6'h30, 16'h0007, 2'h0);
    wr(6'h31, 16'hFFFF, 2'h3);
    rd(6'h31, 16'h0000, 2'h3);
    $display("test unmapped done");
    test_done();
  end
endmodule // test_adc_channel_calibration_registers
bind acr_regs acr_regs_chk u_acr_regs_chk (.clk_sys_i, .rst_n_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_response_o, .avs_waitrequest_o, .ch5_gain_o, .ch5_gain_unity_o,
  .ch6_gain_o, .ch6_gain_unity_o, .ch6_offset_o, .ch6_offset_zero_o, .ch6_input_select_o,
  .ch6_route_o);
